// ===== design/irq_controller.sv
// six-source prioritized interrupt controller with reset sequencing
`timescale 1ns/1ps
`include "irq_defs.svh"
module irq_controller (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reset pin, active low
  input wire logic reset_pin_n,
  // external interrupt pins
  input wire logic ext_pin_one_irq,
  input wire logic ext_pin_two_irq,
  // internal source pulses
  input wire logic serial_irq,
  input wire logic timer_one_overflow_irq,
  input wire logic timer_two_overflow_irq,
  input wire logic interval_timer_irq,
  // instruction sequencer status
  input wire logic instr_done,
  input wire logic timer_proc_pending,
  // latch and enable instructions
  input wire logic enable_and_clear_latches_instr,
  input wire logic disable_and_clear_latches_instr,
  input wire logic clear_latches_instr,
  input wire irq_pkg::latch_vec_type latch_keep,
  input wire logic interrupt_return_instr,
  input wire logic swap_enable_instr,
  input wire irq_pkg::nibble_type acc_in,
  // register views
  output irq_pkg::nibble_type acc_out,
  output irq_pkg::nibble_type per_source_irq_enable,
  output logic master_irq_enable,
  output irq_pkg::latch_vec_type request_latch,
  // acknowledge sequence
  output logic ack_busy,
  output logic ctx_push,
  output logic ctx_pop,
  output logic pc_load,
  output irq_pkg::pc_addr_type pc_load_addr,
  output logic status_flag_set,
  // reset to the core
  output logic core_reset,
  output logic interval_timer_clear
);
  import irq_pkg::*;

  // ===================================================================
  // functions

  // enabled view of the pending latches
  // pin one has no per-source enable
  function automatic latch_vec_type eligible(input latch_vec_type lat,
                                             input nibble_type en);
    latch_vec_type e;
    e = lat;
    e[`LAT_SERIAL] = lat[`LAT_SERIAL] & en[`EN_SERIAL];
    e[`LAT_TMR1] = lat[`LAT_TMR1] & en[`EN_TMR1];
    e[`LAT_TMR2] = lat[`LAT_TMR2] & en[`EN_TMR2_INTV];
    e[`LAT_INTV] = lat[`LAT_INTV] & en[`EN_TMR2_INTV];
    e[`LAT_EXT2] = lat[`LAT_EXT2] & en[`EN_EXT2];
    return e;
  endfunction

  // one-hot of the highest-priority eligible source
  function automatic latch_vec_type pick(input latch_vec_type e);
    latch_vec_type p;
    p = '0;
    if (e[`LAT_EXT1]) begin
      p[`LAT_EXT1] = 1'b1;
    end else if (e[`LAT_SERIAL]) begin
      p[`LAT_SERIAL] = 1'b1;
    end else if (e[`LAT_TMR1]) begin
      p[`LAT_TMR1] = 1'b1;
    end else if (e[`LAT_TMR2]) begin
      p[`LAT_TMR2] = 1'b1;
    end else if (e[`LAT_INTV]) begin
      p[`LAT_INTV] = 1'b1;
    end else if (e[`LAT_EXT2]) begin
      p[`LAT_EXT2] = 1'b1;
    end
    return p;
  endfunction

  // entry address of a one-hot selection
  function automatic pc_addr_type vector_of(input latch_vec_type p);
    pc_addr_type v;
    v = `VEC_EXT2;
    if (p[`LAT_EXT1]) begin
      v = `VEC_EXT1;
    end else if (p[`LAT_SERIAL]) begin
      v = `VEC_SERIAL;
    end else if (p[`LAT_TMR1]) begin
      v = `VEC_TMR1;
    end else if (p[`LAT_TMR2]) begin
      v = `VEC_TMR2;
    end else if (p[`LAT_INTV]) begin
      v = `VEC_INTV;
    end
    return v;
  endfunction

  // ===================================================================
  // declarations

  logic pin_reset;
  logic pin_release;
  logic init;
  logic ext1_fall;
  logic ext2_fall;
  latch_vec_type raise;
  latch_vec_type sel;
  latch_vec_type acc_clear;
  latch_vec_type instr_clear;
  logic can_accept;
  logic take;
  ack_state_type state_r;
  ack_state_type state_nxt;
  latch_vec_type latch_r;
  latch_vec_type latch_nxt;
  nibble_type en_r;
  logic master_r;
  pc_addr_type vec_r;

  // ===================================================================
  // reset pin and external edges

  reset_pin_filter #(
    .LOW_MIN(`RST_LOW_MIN_CYC)
  ) u_reset (
    .clk(clk),
    .rst(rst),
    .reset_pin_n(reset_pin_n),
    .pin_reset(pin_reset),
    .pin_release(pin_release)
  );

  assign init = rst | pin_reset;

  pin_fall_detect u_ext1 (
    .clk(clk),
    .rst(init),
    .pin(ext_pin_one_irq),
    .fall(ext1_fall)
  );

  pin_fall_detect u_ext2 (
    .clk(clk),
    .rst(init),
    .pin(ext_pin_two_irq),
    .fall(ext2_fall)
  );

  // ===================================================================
  // request sources

  always_comb begin
    raise = '0;
    // pin one edges latch even as I/O
    raise[`LAT_EXT1] = ext1_fall;
    raise[`LAT_SERIAL] = serial_irq;
    raise[`LAT_TMR1] = timer_one_overflow_irq;
    raise[`LAT_TMR2] = timer_two_overflow_irq;
    raise[`LAT_INTV] = interval_timer_irq;
    raise[`LAT_EXT2] = ext2_fall;
  end

  // ===================================================================
  // acceptance

  assign sel = pick(eligible(latch_r, en_r));

  assign can_accept = master_r & (sel != '0);

  // taken only at an instruction boundary
  assign take = (state_r == ACK_IDLE) & instr_done & can_accept;

  // ===================================================================
  // acknowledge sequencer

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ACK_IDLE: begin
        if (take) begin
          if (timer_proc_pending) begin
            state_nxt = ACK_WAIT;
          end else begin
            state_nxt = ACK_SAVE;
          end
        end
      end
      ACK_WAIT: begin
        if (!timer_proc_pending) begin
          state_nxt = ACK_SAVE;
        end
      end
      ACK_SAVE: begin
        state_nxt = ACK_LOAD;
      end
      ACK_LOAD: begin
        state_nxt = ACK_IDLE;
      end
      default: begin
        state_nxt = ACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (init) begin
      state_r <= ACK_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (init) begin
      vec_r <= `PC_RESET_ADDR;
    end else if (take) begin
      vec_r <= vector_of(sel);
    end
  end

  // ===================================================================
  // request latches

  assign acc_clear = take ? sel : '0;

  // zero bit in operand clears, one holds
  assign instr_clear = (enable_and_clear_latches_instr | disable_and_clear_latches_instr
                        | clear_latches_instr) ? ~latch_keep : '0;

  // held until accepted or cleared; a new raise wins
  assign latch_nxt = (latch_r & ~(acc_clear | instr_clear)) | raise;

  always_ff @(posedge clk) begin
    if (init) begin
      latch_r <= `LAT_RESET;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // ===================================================================
  // master enable

  always_ff @(posedge clk) begin
    if (init) begin
      master_r <= `MASTER_RESET;
    end else if (take) begin
      master_r <= 1'b0;
    end else if (interrupt_return_instr || enable_and_clear_latches_instr) begin
      master_r <= 1'b1;
    end else if (disable_and_clear_latches_instr) begin
      master_r <= 1'b0;
    end
  end

  // ===================================================================
  // per-source enable register

  always_ff @(posedge clk) begin
    if (init) begin
      en_r <= `EN_RESET;
    end else if (swap_enable_instr) begin
      en_r <= acc_in;
    end
  end

  always_ff @(posedge clk) begin
    if (init) begin
      acc_out <= '0;
    end else if (swap_enable_instr) begin
      acc_out <= en_r;
    end
  end

  // ===================================================================
  // acknowledge and return outputs

  // push in the first cycle after any timer wait, vector in the next
  // only the core's program counter and flags are pushed
  always_ff @(posedge clk) begin
    if (init) begin
      ctx_push <= 1'b0;
      ctx_pop <= 1'b0;
      pc_load <= 1'b0;
      pc_load_addr <= `PC_RESET_ADDR;
      status_flag_set <= 1'b1;
    end else begin
      ctx_push <= (state_nxt == ACK_SAVE);
      ctx_pop <= interrupt_return_instr;
      // fetch at zero when pin reset ends
      pc_load <= (state_nxt == ACK_LOAD) | pin_release;
      status_flag_set <= (state_nxt == ACK_LOAD);
      if (state_nxt == ACK_LOAD) begin
        pc_load_addr <= vec_r;
      end else if (pin_release) begin
        pc_load_addr <= `PC_RESET_ADDR;
      end
    end
  end

  // reset held to core and interval timer
  always_ff @(posedge clk) begin
    if (rst) begin
      core_reset <= 1'b1;
      interval_timer_clear <= 1'b1;
    end else begin
      core_reset <= pin_reset;
      interval_timer_clear <= pin_reset;
    end
  end

  // lower request waits for the next boundary
  assign ack_busy = (state_r != ACK_IDLE) | take;

  assign per_source_irq_enable = en_r;
  assign master_irq_enable = master_r;
  assign request_latch = latch_r;

endmodule

// ===== inc/irq_defs.svh
// constants for the prioritized interrupt and reset block
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// request latch positions, highest priority at the top
`define LAT_EXT1 5
`define LAT_SERIAL 4
`define LAT_TMR1 3
`define LAT_TMR2 2
`define LAT_INTV 1
`define LAT_EXT2 0
`define LAT_COUNT 6

// per-source enable bit positions
`define EN_SERIAL 3
`define EN_TMR1 2
`define EN_TMR2_INTV 1
`define EN_EXT2 0

// entry addresses
`define VEC_EXT1 12'h002
`define VEC_SERIAL 12'h004
`define VEC_TMR1 12'h006
`define VEC_TMR2 12'h008
`define VEC_INTV 12'h00A
`define VEC_EXT2 12'h00C

// reset values
`define PC_RESET_ADDR 12'h000
`define EN_RESET 4'h0
`define LAT_RESET 6'h00
`define MASTER_RESET 1'h0

// timing, in instruction cycles (one clk per instruction cycle)
`define RST_LOW_MIN_CYC 3
`define ACK_CYC 2

`endif

// ===== inc/irq_pkg.sv
// types shared by the interrupt and reset block
package irq_pkg;

  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_WAIT = 2'b01,
    ACK_SAVE = 2'b10,
    ACK_LOAD = 2'b11
  } ack_state_type;

  typedef logic [5:0] latch_vec_type;
  typedef logic [3:0] nibble_type;
  typedef logic [11:0] pc_addr_type;

endpackage

// ===== design/pin_fall_detect.sv
// two-stage synchroniser and falling-edge detector for an external pin
`timescale 1ns/1ps
module pin_fall_detect (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and event
  input wire logic pin,
  output logic fall
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // =====================================================
  // synchroniser, idle level is high
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // =====================================================
  // edge pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      fall <= 1'b0;
    end else begin
      fall <= last_r & ~sync_r;
    end
  end

endmodule

// ===== design/reset_pin_filter.sv
// reset pin qualifier: low for a minimum count of cycles starts reset
`timescale 1ns/1ps
`include "irq_defs.svh"
module reset_pin_filter #(
  parameter int LOW_MIN = `RST_LOW_MIN_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin
  input wire logic reset_pin_n,
  // qualified reset
  output logic pin_reset,
  output logic pin_release
);

  localparam int CW = $clog2(LOW_MIN + 1);

  logic meta_r;
  logic sync_r;
  logic [CW-1:0] low_cnt_r;

  // =====================================================
  // synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= reset_pin_n;
      sync_r <= meta_r;
    end
  end

  // =====================================================
  // low-time counter
  always_ff @(posedge clk) begin
    if (rst || sync_r) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != CW'(LOW_MIN)) begin
      low_cnt_r <= low_cnt_r + CW'(1);
    end
  end

  // =====================================================
  // reset level and release pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_reset <= 1'b0;
      pin_release <= 1'b0;
    end else begin
      pin_release <= pin_reset & sync_r;
      if (sync_r) begin
        pin_reset <= 1'b0;
      end else if (low_cnt_r == CW'(LOW_MIN - 1)) begin
        pin_reset <= 1'b1;
      end
    end
  end

endmodule

// ===== tb/irq_ctrl_props.sv
// checker for the interrupt controller ports
`timescale 1ns/1ps
module irq_ctrl_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instructions
  input wire logic instr_done,
  input wire logic timer_proc_pending,
  input wire logic swap_enable_instr,
  input wire logic clear_latches_instr,
  input wire logic interrupt_return_instr,
  input wire irq_pkg::latch_vec_type latch_keep,
  input wire irq_pkg::nibble_type acc_in,
  // controller state
  input wire irq_pkg::nibble_type acc_out,
  input wire irq_pkg::nibble_type per_source_irq_enable,
  input wire logic master_irq_enable,
  input wire irq_pkg::latch_vec_type request_latch,
  // acknowledge and reset
  input wire logic ack_busy,
  input wire logic ctx_push,
  input wire logic ctx_pop,
  input wire logic pc_load,
  input wire irq_pkg::pc_addr_type pc_load_addr,
  input wire logic status_flag_set,
  input wire logic core_reset
);
  import irq_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  latch_vec_type gate;
  assign gate = {1'b1, per_source_irq_enable[3:1], per_source_irq_enable[1:0]};
  // ========
  // acceptance
  property p_accept; $rose(ack_busy) |-> instr_done && master_irq_enable; endproperty
  a_accept: assert property (p_accept) else $error("accept while disabled");
  property p_gate; $rose(ack_busy) |-> (request_latch & gate) != 6'h00; endproperty
  a_gate: assert property (p_gate) else $error("masked source accepted");
  property p_off; $rose(ack_busy) |=> !master_irq_enable; endproperty
  a_off: assert property (p_off) else $error("master left on");
  property p_seq; $rose(ack_busy) |-> ##[1:20] ctx_push ##1 (pc_load && status_flag_set); endproperty
  a_seq: assert property (p_seq) else $error("acknowledge order");
  property p_defer; timer_proc_pending |=> !ctx_push; endproperty
  a_defer: assert property (p_defer) else $error("push during timer work");
  property p_top; $rose(ack_busy) && request_latch[5] |-> ##[2:21] pc_load_addr == 12'h002 && pc_load;
  endproperty
  a_top: assert property (p_top) else $error("top vector wrong");
  // ========
  // instructions and reset
  property p_ret; interrupt_return_instr && !ack_busy |=> master_irq_enable && ctx_pop; endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_clr; clear_latches_instr && !ack_busy |=> (request_latch & ~$past(latch_keep)) == 6'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("latch not cleared");
  property p_swap;
    swap_enable_instr |=> per_source_irq_enable == $past(acc_in) &&
      acc_out == $past(per_source_irq_enable);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_reset;
    @(posedge clk) disable iff (1'b0) rst |=> !master_irq_enable && request_latch == 6'h00 &&
      per_source_irq_enable == 4'h0 && status_flag_set && core_reset;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  c_ack: cover property ($rose(ack_busy));
  c_pop: cover property (ctx_pop);
  c_home: cover property (pc_load && pc_load_addr == 12'h000);
  c_wait: cover property (ack_busy && timer_proc_pending);
endmodule

// ===== tb/cpu_seq_model.sv
// instruction sequencer model: boundaries and timer stalls
`timescale 1ns/1ps
module cpu_seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controller status
  input wire logic ack_busy,
  input wire logic core_reset,
  input wire logic slow,
  // sequencer outputs
  output logic instr_done,
  output logic timer_proc_pending
);
  logic [1:0] cyc_r;
  logic [1:0] stall_r;
  assign timer_proc_pending = stall_r != 2'h0;
  always_ff @(posedge clk) begin
    if (rst || core_reset) begin
      cyc_r <= 2'h0;
      instr_done <= 1'b0;
    end else begin
      cyc_r <= cyc_r + 2'h1;
      instr_done <= cyc_r == 2'h3 && !ack_busy;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      stall_r <= 2'h0;
    end else if (slow && cyc_r == 2'h3 && !ack_busy) begin
      stall_r <= 2'h3;
    end else if (stall_r != 2'h0) begin
      stall_r <= stall_r - 2'h1;
    end
  end
endmodule

// ===== tb/prioritized_interrupt_and_reset_test.sv
// self-checking bench for the interrupt and reset block
`timescale 1ns/1ps
module prioritized_interrupt_and_reset_test;
  import irq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_n = 1'b1, ext_pin_one_irq = 1'b1, ext_pin_two_irq = 1'b1, slow = 1'b0;
  logic serial_irq = 1'b0, timer_one_overflow_irq = 1'b0, timer_two_overflow_irq = 1'b0;
  logic interval_timer_irq = 1'b0, swap_enable_instr = 1'b0, interrupt_return_instr = 1'b0;
  logic enable_and_clear_latches_instr = 1'b0, disable_and_clear_latches_instr = 1'b0;
  logic clear_latches_instr = 1'b0;
  latch_vec_type latch_keep = 6'h3F;
  nibble_type acc_in = 4'h0;
  nibble_type acc_out, per_source_irq_enable, v, old;
  latch_vec_type request_latch;
  pc_addr_type pc_load_addr, e;
  logic instr_done, timer_proc_pending, master_irq_enable, ack_busy, ctx_push, ctx_pop;
  logic pc_load, status_flag_set, core_reset, interval_timer_clear;
  pc_addr_type exp_q[$];
  int fails = 0;
  int num_checks = 0;
  integer seed = 60;
  always #12.5 clk = ~clk;
  irq_controller irq_controller_inst (
    .clk(clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .ext_pin_one_irq(ext_pin_one_irq), .ext_pin_two_irq(ext_pin_two_irq),
    .serial_irq(serial_irq), .timer_one_overflow_irq(timer_one_overflow_irq),
    .timer_two_overflow_irq(timer_two_overflow_irq), .interval_timer_irq(interval_timer_irq),
    .instr_done(instr_done), .timer_proc_pending(timer_proc_pending),
    .enable_and_clear_latches_instr(enable_and_clear_latches_instr),
    .disable_and_clear_latches_instr(disable_and_clear_latches_instr),
    .clear_latches_instr(clear_latches_instr), .latch_keep(latch_keep),
    .interrupt_return_instr(interrupt_return_instr), .swap_enable_instr(swap_enable_instr),
    .acc_in(acc_in), .acc_out(acc_out), .per_source_irq_enable(per_source_irq_enable),
    .master_irq_enable(master_irq_enable), .request_latch(request_latch),
    .ack_busy(ack_busy), .ctx_push(ctx_push), .ctx_pop(ctx_pop), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .status_flag_set(status_flag_set),
    .core_reset(core_reset), .interval_timer_clear(interval_timer_clear)
  );
  cpu_seq_model cpu_seq_model_inst (
    .clk(clk), .rst(rst), .ack_busy(ack_busy), .core_reset(core_reset), .slow(slow),
    .instr_done(instr_done), .timer_proc_pending(timer_proc_pending)
  );
  // ========
  // shared tasks
  task automatic chk(input logic [11:0] g, input logic [11:0] x);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic op(input int k, input latch_vec_type m);
    @(posedge clk);
    latch_keep <= m;
    acc_in <= m[3:0];
    enable_and_clear_latches_instr <= k == 0;
    disable_and_clear_latches_instr <= k == 1;
    clear_latches_instr <= k == 2;
    interrupt_return_instr <= k == 3;
    swap_enable_instr <= k == 4;
    @(posedge clk);
    enable_and_clear_latches_instr <= 1'b0;
    disable_and_clear_latches_instr <= 1'b0;
    clear_latches_instr <= 1'b0;
    interrupt_return_instr <= 1'b0;
    swap_enable_instr <= 1'b0;
    @(negedge clk);
  endtask
  // pins held low three and high six cycles
  task automatic src(input latch_vec_type m);
    @(posedge clk);
    {ext_pin_one_irq, serial_irq, timer_one_overflow_irq} <= {~m[5], m[4], m[3]};
    {timer_two_overflow_irq, interval_timer_irq, ext_pin_two_irq} <= {m[2], m[1], ~m[0]};
    @(posedge clk);
    {serial_irq, timer_one_overflow_irq, timer_two_overflow_irq, interval_timer_irq} <= 4'h0;
    repeat (2) @(posedge clk);
    {ext_pin_one_irq, ext_pin_two_irq} <= 2'b11;
    repeat (6) @(negedge clk);
  endtask
  task automatic wl;
    int n;
    for (n = 0; n < 60; n++) begin
      @(negedge clk);
      if (pc_load === 1'b1) break;
    end
    if (n == 60) chk(12'h000, 12'h001);
  endtask
  // ========
  // result watcher
  always @(posedge clk) begin
    if (pc_load === 1'b1 && !(exp_q.size() == 0 && pc_load_addr === 12'h000)) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 12'hFFF;
      chk(pc_load_addr, e);
      if (e != 12'h000) chk(12'(status_flag_set), 12'h001);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
  // ========
  // main sequence
  initial begin
    old = 4'h0;
    repeat (10) @(negedge clk);
    chk(12'({master_irq_enable, request_latch, per_source_irq_enable}), 12'h000);
    chk(12'({status_flag_set, core_reset, interval_timer_clear}), 12'h007);
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      v = 4'($random(seed));
      op(4, {2'b11, v});
      chk(12'(per_source_irq_enable), 12'(v));
      chk(12'(acc_out), 12'(old));
      old = v;
    end
    op(4, 6'h0F);
    src(6'h3F);
    repeat (20) @(negedge clk);
    chk(12'({master_irq_enable, request_latch}), 12'h03F);
    for (int i = 0; i < 6; i++) exp_q.push_back(12'h002 + 12'(2 * i));
    op(0, 6'h3F);
    for (int i = 0; i < 6; i++) begin
      wl();
      op(3, 6'h3F);
    end
    chk(12'({master_irq_enable, request_latch}), 12'h040);
    op(4, 6'h00);
    src(6'h1F);
    repeat (20) @(negedge clk);
    chk(12'({master_irq_enable, request_latch}), 12'h05F);
    op(2, 6'h2A);
    chk(12'(request_latch), 12'h00A);
    op(1, 6'h00);
    chk(12'({master_irq_enable, request_latch}), 12'h000);
    @(posedge clk);
    slow <= 1'b1;
    exp_q.push_back(12'h002);
    src(6'h20);
    op(0, 6'h3F);
    wl();
    op(3, 6'h3F);
    op(4, 6'h05);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_pin_n <= 1'b1;
    repeat (10) @(negedge clk);
    chk(12'({core_reset, per_source_irq_enable}), 12'h005);
    exp_q.push_back(12'h000);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_pin_n <= 1'b1;
    wl();
    repeat (3) @(negedge clk);
    chk(12'({master_irq_enable, request_latch, per_source_irq_enable}), 12'h000);
    chk(12'(exp_q.size()), 12'h000);
    finish_test();
  end
endmodule
bind irq_controller irq_ctrl_props irq_ctrl_props_inst (
  .clk(clk), .rst(rst), .instr_done(instr_done), .timer_proc_pending(timer_proc_pending),
  .swap_enable_instr(swap_enable_instr), .clear_latches_instr(clear_latches_instr),
  .interrupt_return_instr(interrupt_return_instr), .latch_keep(latch_keep), .acc_in(acc_in),
  .acc_out(acc_out), .per_source_irq_enable(per_source_irq_enable),
  .master_irq_enable(master_irq_enable), .request_latch(request_latch), .ack_busy(ack_busy),
  .ctx_push(ctx_push), .ctx_pop(ctx_pop), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
  .status_flag_set(status_flag_set), .core_reset(core_reset)
);
